// [rtl/mprc_power_reset.sv]
// power-state and reset control at the carrier connector
// assumes pins arrive asynchronously and one always-on clock clk
`timescale 1ns/100ps
`default_nettype none

// Function
// - power event for 50 ms to 4 s press
// - event wakes from sleep, powers down when running
// - press of 4 s or more forces off
// - rails enabled only after supply good
// - no power-up while supply good low
// - reset key handled as level, consistently
// - firmware polls reset key via status output
// - board reset from key, supply, watchdog, software
// - board reset held low while key low
// - supports S3, S4 and S5 states
// - ram sleep status low only in S3 and while rst_n holds reset
// - disk/off status low in S4 or S5
module mprc_power_reset #(
  parameter int unsigned PRESS_MIN = mprc_pkg::PRESS_MIN_CYC,
  parameter int unsigned PRESS_OVR = mprc_pkg::PRESS_OVR_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // carrier pins
  input wire logic power_key_n,
  input wire logic reset_key_n,
  input wire logic supply_good_in,
  // on-module reset sources and sleep requests
  input wire logic watchdog_reset,
  input wire logic soft_reset,
  input wire logic sleep_req,
  input wire mprc_pkg::mprc_state_e sleep_target,
  // outputs
  output var logic board_reset_out_n,
  output var logic sleep_ram_status_n,
  output var logic sleep_disk_off_status_n,
  output var logic rails_en,
  output var logic reset_key_status_n,
  output var logic power_event
);
  import mprc_pkg::*;

  // ==========================================
  // input synchronisers
  mprc_in_s meta_q, sync_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= IN_IDLE;
      sync_q <= IN_IDLE;
    end else begin
      meta_q <= '{power_key_n: power_key_n, reset_key_n: reset_key_n, supply_good: supply_good_in};
      sync_q <= meta_q;
    end
  end

  // ==========================================
  // press timer
  logic [CNT_W-1:0] press_cnt_q, press_cnt_d;
  logic key_prev_q, key_prev_d;
  logic ovr_done_q, ovr_done_d;
  logic press_evt, ovr_evt;
  always_comb begin
    press_cnt_d = press_cnt_q;
    key_prev_d = sync_q.power_key_n;
    ovr_done_d = ovr_done_q;
    press_evt = 1'b0;
    ovr_evt = 1'b0;
    if (!sync_q.power_key_n) begin
      if (key_prev_q) begin
        press_cnt_d = CNT_W'(1);
        ovr_done_d = 1'b0;
      end else if (press_cnt_q < CNT_W'(PRESS_OVR)) begin
        press_cnt_d = press_cnt_q + CNT_W'(1);
      end
      // override fires once the low level reaches the threshold
      if (press_cnt_d >= CNT_W'(PRESS_OVR) && !ovr_done_q) begin
        ovr_evt = 1'b1;
        ovr_done_d = 1'b1;
      end
    end else if (!key_prev_q) begin
      // release: qualify the measured low time
      if (press_cnt_q >= CNT_W'(PRESS_MIN) && press_cnt_q < CNT_W'(PRESS_OVR)) begin
        press_evt = 1'b1;
      end
      press_cnt_d = '0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      press_cnt_q <= '0;
      key_prev_q <= 1'b1;
      ovr_done_q <= 1'b0;
    end else begin
      press_cnt_q <= press_cnt_d;
      key_prev_q <= key_prev_d;
      ovr_done_q <= ovr_done_d;
    end
  end

  // ==========================================
  // power state machine
  mprc_state_e state_q, state_d;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MPRC_S5: begin
        // soft-off: only a qualified press starts the way up
        if (press_evt) state_d = MPRC_UP;
      end
      MPRC_UP: begin
        // wait here while the carrier holds supply good low
        if (sync_q.supply_good) state_d = MPRC_S0;
      end
      MPRC_S0: begin
        if (press_evt) state_d = MPRC_DN;
        else if (sleep_req && sleep_target == MPRC_S3) state_d = MPRC_S3;
        else if (sleep_req && sleep_target == MPRC_S4) state_d = MPRC_S4;
        else if (!sync_q.supply_good) state_d = MPRC_UP;
      end
      MPRC_DN: begin
        // one cycle with rails dropped before the off state is shown
        state_d = MPRC_S5;
      end
      MPRC_S3: begin
        // memory kept alive; a press resumes through the supply check
        if (press_evt) state_d = MPRC_UP;
      end
      MPRC_S4: begin
        if (press_evt) state_d = MPRC_UP;
      end
      default: begin
        // the two unused codes fall back to off
        state_d = MPRC_S5;
      end
    endcase
    // override beats every other transition; it never shares a cycle with a release, which needs the key high
    if (ovr_evt) begin
      state_d = MPRC_S5;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= MPRC_S5;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================
  // board reset and outputs, all registered
  // level-sensitive reset key: simpler and gives the hold-in-reset behaviour for free
  logic [$clog2(RST_HOLD_CYC+1)-1:0] hold_q, hold_d;
  logic rst_src;
  mprc_out_s out_q, out_d;
  logic evt_q;
  always_comb begin
    rst_src = !sync_q.reset_key_n || !sync_q.supply_good || watchdog_reset || soft_reset
              || state_q != MPRC_S0;
    hold_d = hold_q;
    if (rst_src) hold_d = '0;
    else if (hold_q != ($bits(hold_q))'(RST_HOLD_CYC)) hold_d = hold_q + 1'b1;
    out_d.board_reset_out_n = !rst_src && hold_q == ($bits(hold_q))'(RST_HOLD_CYC);
    out_d.sleep_ram_status_n = state_d != MPRC_S3;
    out_d.sleep_disk_off_status_n = !(state_d == MPRC_S4 || state_d == MPRC_S5);
    out_d.rails_en = (state_d == MPRC_S0) && sync_q.supply_good;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
      out_q <= OUT_RST;
      evt_q <= 1'b0;
      reset_key_status_n <= 1'b1;
    end else begin
      hold_q <= hold_d;
      out_q <= out_d;
      evt_q <= press_evt;
      reset_key_status_n <= sync_q.reset_key_n;
    end
  end
  assign board_reset_out_n = out_q.board_reset_out_n;
  assign sleep_ram_status_n = out_q.sleep_ram_status_n;
  assign sleep_disk_off_status_n = out_q.sleep_disk_off_status_n;
  assign rails_en = out_q.rails_en;
  assign power_event = evt_q;

  // ==========================================
  // checks
  a_reset_key_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !sync_q.reset_key_n |=> !board_reset_out_n) else $error("board reset released while key low");
  a_rails_need_good: assert property (@(posedge clk) disable iff (!rst_n)
    rails_en |-> $past(sync_q.supply_good)) else $error("rails on without supply good");
  a_no_up_wo_good: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MPRC_UP && !sync_q.supply_good && !ovr_evt |=> state_q == MPRC_UP)
    else $error("power-up without supply good");
  a_override_off: assert property (@(posedge clk) disable iff (!rst_n)
    ovr_evt |=> state_q == MPRC_S5 ##1 !sleep_disk_off_status_n) else $error("override did not power off");
  a_event_window: assert property (@(posedge clk) disable iff (!rst_n)
    power_event |-> $past(press_cnt_q) >= CNT_W'(PRESS_MIN) && $past(press_cnt_q) < CNT_W'(PRESS_OVR))
    else $error("power event outside press window");
  a_wake_from_off: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MPRC_S5 && press_evt && !ovr_evt |=> state_q == MPRC_UP) else $error("event did not wake");
  a_ram_status: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MPRC_S3 |-> !sleep_ram_status_n) else $error("ram status wrong in S3");
  a_disk_status: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MPRC_S0 |-> sleep_disk_off_status_n) else $error("disk status low while running");
  a_reset_sources: assert property (@(posedge clk) disable iff (!rst_n)
    watchdog_reset || soft_reset |=> !board_reset_out_n) else $error("reset source ignored");
  a_key_status: assert property (@(posedge clk) disable iff (!rst_n)
    reset_key_status_n == $past(sync_q.reset_key_n)) else $error("reset key status stale");
  c_power_on: cover property (@(posedge clk) disable iff (!rst_n) state_q == MPRC_UP ##1 state_q == MPRC_S0);
  c_override: cover property (@(posedge clk) disable iff (!rst_n) ovr_evt);
  c_enter_s3: cover property (@(posedge clk) disable iff (!rst_n) state_q == MPRC_S3);
  c_reset_rel: cover property (@(posedge clk) disable iff (!rst_n) $rose(board_reset_out_n));
  c_enter_s4: cover property (@(posedge clk) disable iff (!rst_n) state_q == MPRC_S4);

  // ==========================================
  // event shape
  // a release needs a low cycle before it, so two pulses can never touch
  a_event_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    power_event |=> !power_event)
    else $error("power event longer than one cycle");
  a_event_on_release: assert property (@(posedge clk) disable iff (!rst_n)
    power_event |-> $past(sync_q.power_key_n))
    else $error("power event while key still low");

  // ==========================================
  // state transitions
  a_power_down: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MPRC_S0 && press_evt && !ovr_evt |=> state_q == MPRC_DN)
    else $error("press while running did not power down");
  a_down_to_off: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MPRC_DN |=> state_q == MPRC_S5)
    else $error("power-down did not reach off");
  a_wake_from_ram: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MPRC_S3 && press_evt && !ovr_evt |=> state_q == MPRC_UP)
    else $error("event did not wake from ram sleep");
  a_wake_from_disk: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MPRC_S4 && press_evt && !ovr_evt |=> state_q == MPRC_UP)
    else $error("event did not wake from disk sleep");
  a_up_with_good: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MPRC_UP && sync_q.supply_good && !ovr_evt |=> state_q == MPRC_S0)
    else $error("power-up stalled with supply good");
  a_sleep_ram_entry: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MPRC_S0 && sleep_req && sleep_target == MPRC_S3 && !press_evt && !ovr_evt
    |=> state_q == MPRC_S3)
    else $error("ram sleep request not taken");

  // ==========================================
  // outputs against state
  // rails are registered from the next state, so they line up with state_q and can never lead it
  a_rails_only_s0: assert property (@(posedge clk) disable iff (!rst_n)
    rails_en |-> state_q == MPRC_S0)
    else $error("rails on outside running state");
  a_reset_off_state: assert property (@(posedge clk) disable iff (!rst_n)
    state_q != MPRC_S0 |=> !board_reset_out_n)
    else $error("board reset released outside running state");
  a_reset_supply: assert property (@(posedge clk) disable iff (!rst_n)
    !sync_q.supply_good |=> !board_reset_out_n)
    else $error("board reset released without supply good");
  // the reset value of the sleep status pins is low, so skip the first edge
  a_ram_high_else: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && state_q != MPRC_S3 |-> sleep_ram_status_n)
    else $error("ram status low outside ram sleep");
  a_disk_low_off: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MPRC_S4 || state_q == MPRC_S5 |-> !sleep_disk_off_status_n)
    else $error("disk status high in disk sleep or off");

endmodule // mprc_power_reset
`default_nettype wire

// [common/mprc_pkg.sv]
// package for the module power and reset control block
// assumes a 100 MHz always-on clock; the press timing counts derive from it
package mprc_pkg;

  // ==========================================
  // clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned PRESS_MIN_MS = 50;
  localparam int unsigned PRESS_OVR_MS = 4000;
  localparam int unsigned PRESS_TYP_MS = 400;
  localparam int unsigned MS_DIV = 1000;
  // least time is whole ms times truncated cycles per ms, the override threshold is a least time as well
  localparam int unsigned PRESS_MIN_CYC = (CLK_HZ / MS_DIV) * PRESS_MIN_MS;
  localparam int unsigned PRESS_OVR_CYC = (CLK_HZ / MS_DIV) * PRESS_OVR_MS;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned RST_HOLD_CYC = 16;

  // ==========================================
  // power states, gray along off -> on -> off paths and S0 -> S4
  typedef enum logic [2:0] {
    MPRC_S5 = 3'b000,
    MPRC_UP = 3'b001,
    MPRC_S0 = 3'b011,
    MPRC_DN = 3'b010,
    MPRC_S3 = 3'b110,
    MPRC_S4 = 3'b111
  } mprc_state_e;

  // ==========================================
  // synchronised carrier inputs
  typedef struct packed {
    logic power_key_n;
    logic reset_key_n;
    logic supply_good;
  } mprc_in_s;

  // status outputs
  typedef struct packed {
    logic board_reset_out_n;
    logic sleep_ram_status_n;
    logic sleep_disk_off_status_n;
    logic rails_en;
  } mprc_out_s;

  localparam mprc_in_s IN_IDLE = '{power_key_n: 1'b1, reset_key_n: 1'b1, supply_good: 1'b0};
  localparam mprc_out_s OUT_RST = '{board_reset_out_n: 1'b0, sleep_ram_status_n: 1'b0,
                                     sleep_disk_off_status_n: 1'b0, rails_en: 1'b0};

endpackage : mprc_pkg

// [verif/mprc_carrier_model.sv]
// carrier-side model: power key, reset key and supply-good pin
// assumes clk is the module's always-on clock; pins change on its falling edge
`timescale 1ns/100ps
`default_nettype none
module mprc_carrier_model (
  // clock
  input wire logic clk,
  // carrier pins
  output var logic power_key_n,
  output var logic reset_key_n,
  output var logic supply_good_in
);
  // ==========================================
  // idle carrier: keys up, supply held off until the bench says ready
  initial begin
    power_key_n = 1'b1;
    reset_key_n = 1'b1;
    supply_good_in = 1'b0;
  end
  // ==========================================
  // key presses, length in clock cycles
  task automatic press(input int n);
    @(negedge clk) power_key_n = 1'b0;
    repeat (n) @(negedge clk);
    power_key_n = 1'b1;
  endtask
  task automatic hold_reset(input int n);
    @(negedge clk) reset_key_n = 1'b0;
    repeat (n) @(negedge clk);
    reset_key_n = 1'b1;
  endtask
  // supply stays up while running; dropping it stands for a power failure only
  task automatic supply(input logic v);
    @(negedge clk) supply_good_in = v;
  endtask
endmodule // mprc_carrier_model
`default_nettype wire

// [verif/tb_mprc_power_reset.sv]
// testbench: drives key, supply and sleep ports, checks against a state model
// assumes short press counts via parameters so runs stay brief
`timescale 1ns/100ps
`default_nettype none
module tb_mprc_power_reset;
  import mprc_pkg::*;
  localparam int unsigned P_MIN = 10;
  localparam int unsigned P_OVR = 50;
  logic clk, rst_n, watchdog_reset, soft_reset, sleep_req;
  mprc_state_e sleep_target;
  wire logic power_key_n, reset_key_n, supply_good_in;
  logic brst_n, sram_n, sdisk_n, rails, rk_n, pev;
  int failures = 0, compares = 0, events = 0, exp_ev = 0, exp_st = 5, n;
  // ==========================================
  // design and carrier
  mprc_power_reset #(.PRESS_MIN(P_MIN), .PRESS_OVR(P_OVR)) u_mprc_power_reset (.clk(clk), .rst_n(rst_n),
    .power_key_n(power_key_n), .reset_key_n(reset_key_n), .supply_good_in(supply_good_in),
    .watchdog_reset(watchdog_reset), .soft_reset(soft_reset), .sleep_req(sleep_req),
    .sleep_target(sleep_target), .board_reset_out_n(brst_n), .sleep_ram_status_n(sram_n),
    .sleep_disk_off_status_n(sdisk_n), .rails_en(rails), .reset_key_status_n(rk_n), .power_event(pev));
  mprc_carrier_model u_mprc_carrier_model (.clk(clk), .power_key_n(power_key_n),
    .reset_key_n(reset_key_n), .supply_good_in(supply_good_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (pev === 1'b1) events++;
  // ==========================================
  // compare and close
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // model states: 5 off, 1 powering up, 0 running, 3 and 4 asleep
  task automatic settle_check();
    repeat (40) @(negedge clk);
    chk(rails, 32'(exp_st == 0));
    chk(brst_n, 32'(exp_st == 0));
    if (exp_st != 1) chk(sram_n, 32'(exp_st != 3));
    if (exp_st != 1) chk(sdisk_n, 32'(exp_st < 4));
    chk(events, exp_ev);
  endtask
  task automatic key(input int len, input int st);
    u_mprc_carrier_model.press(len);
    exp_ev += (len >= P_MIN && len < P_OVR);
    exp_st = st;
    settle_check();
  endtask
  initial begin : wdog
    repeat (8000) @(posedge clk);
    failures++;
    print_verdict();
  end
  // ==========================================
  // scenarios
  initial begin
    {rst_n, watchdog_reset, soft_reset, sleep_req} = 4'h0;
    sleep_target = MPRC_S3;
    n = $urandom(21);
    repeat (8) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    settle_check();
    key(P_MIN, 1);
    u_mprc_carrier_model.supply(1'b1);
    exp_st = 0;
    settle_check();
    key(P_MIN - 2, 0);
    key(P_MIN + $urandom % (P_OVR - P_MIN), 5);
    key(P_OVR - 1, 0);
    for (int i = 0; i < 2; i++) begin
      @(negedge clk) sleep_target = i ? MPRC_S4 : MPRC_S3;
      sleep_req = 1'b1;
      @(negedge clk) sleep_req = 1'b0;
      exp_st = i ? 4 : 3;
      settle_check();
      key(P_MIN + $urandom % 20, 0);
    end
    fork u_mprc_carrier_model.hold_reset(60); join_none
    repeat (4) @(negedge clk);
    chk(rk_n, 0);
    repeat (50) @(negedge clk) chk(brst_n, 0);
    settle_check();
    for (int i = 0; i < 2; i++) begin
      @(negedge clk) {watchdog_reset, soft_reset} = i ? 2'b01 : 2'b10;
      repeat (3) @(negedge clk);
      chk(brst_n, 0);
      {watchdog_reset, soft_reset} = 2'b00;
      settle_check();
    end
    u_mprc_carrier_model.supply(1'b0);
    exp_st = 1;
    settle_check();
    u_mprc_carrier_model.supply(1'b1);
    exp_st = 0;
    settle_check();
    fork u_mprc_carrier_model.press(P_OVR + 40); join_none
    repeat (P_OVR + 10) @(negedge clk);
    chk(rails, 0);
    exp_st = 5;
    repeat (30) @(negedge clk);
    settle_check();
    print_verdict();
  end
endmodule // tb_mprc_power_reset
`default_nettype wire
